// ---- design/mbox_pkg.sv ----
// Constants shared by the command mailbox and its network transaction engine.
// Assumes every mailbox and network port runs on the one block clock.
// Summary of operation
// [RULE_01] The configuration read answers with a result code, then the identity code and I/O configuration, each held to four bits.
// [RULE_02] The address change takes the old address in the first parameter byte and the new one in the second, each from 01h to 1fh or 21h to 3fh.
// [RULE_03] The address change is refused with its own result code while a slave at address zero is on the network.
// [RULE_04] The analog input read uses code 29h and accepts slave addresses 01h to 1fh only, ignoring the other parameter bytes.
// [RULE_05] The analog input read returns four channels high byte first, channels 1 and 2 in the first area and 3 and 4 in the second.
// [RULE_06] The analog output write uses code 2ah with channels 1 and 2 in the first area and 3 and 4 in the second, and answers only a result code.
// [RULE_07] The analog commands run only when the block is built as the later converter revision.
// [RULE_08] The host sends a B slave as its number plus 20h.
// [RULE_09] The host sends a standard or A slave as its plain number from 01h to 1fh.
// [RULE_10] The host fills the command bytes only while both flags are clear, then raises the request flag.
// [RULE_11] On a raised request flag the block runs the command, posts result and response, and only then raises the end flag.
// The block raises END_FLAG on the edge that writes the response image, one cycle before RD_DATA can show it.
// [RULE_12] The block drops the end flag once the host drops the request flag.
// [RULE_13] Result codes are 00h normal, 02h address, 03h inactive, 04h zero slave, 05h network, 06h memory, 07h parameter, 08h not executable, 09h unknown.
// [RULE_14] A slave address outside the range of the command returns the address error without any network traffic.
package mbox_pkg;

	localparam logic [4:0] OFS_CMD = 5'h11;
	localparam logic [4:0] OFS_PRM0 = 5'h12;
	localparam logic [4:0] OFS_PRM1 = 5'h13;
	localparam logic [4:0] OFS_PRM2 = 5'h14;
	localparam logic [4:0] OFS_PRM3 = 5'h15;
	localparam logic [4:0] OFS_PRM4 = 5'h16;
	localparam logic [4:0] OFS_RESULT = 5'h19;
	localparam logic [4:0] OFS_RSP0 = 5'h1a;
	localparam logic [4:0] OFS_RSP1 = 5'h1b;
	localparam logic [4:0] OFS_RSP2 = 5'h1c;
	localparam logic [4:0] OFS_RSP3 = 5'h1d;

	localparam logic [7:0] CMD_READ_CFG = 8'h12;
	localparam logic [7:0] CMD_CHG_ADDR = 8'h17;
	localparam logic [7:0] CMD_AIN = 8'h29;
	localparam logic [7:0] CMD_AOUT = 8'h2a;

	localparam logic [7:0] RES_OK = 8'h00;
	localparam logic [7:0] RES_ADDR = 8'h02;
	localparam logic [7:0] RES_INACTIVE = 8'h03;
	localparam logic [7:0] RES_ZERO_SLAVE = 8'h04;
	localparam logic [7:0] RES_NET = 8'h05;
	localparam logic [7:0] RES_MEMORY = 8'h06;
	localparam logic [7:0] RES_PARAM = 8'h07;
	localparam logic [7:0] RES_NOT_EXEC = 8'h08;
	localparam logic [7:0] RES_UNKNOWN = 8'h09;

	localparam logic [7:0] ADDR_B_OFFSET = 8'h20;
	localparam logic [7:0] ADDR_MIN = 8'h01;
	localparam logic [7:0] ADDR_MAX_A = 8'h1f;
	localparam logic [7:0] ADDR_MAX_B = 8'h3f;
	localparam logic [7:0] NIBBLE_MASK = 8'h0f;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	localparam int NET_TIMEOUT_CYC = 20000;

	typedef enum logic [1:0] {
		OP_READ_CFG = 2'b00,
		OP_CHG_ADDR = 2'b01,
		OP_AIN = 2'b10,
		OP_AOUT = 2'b11
	} net_op_e;

	typedef enum logic [1:0] {
		NST_OK = 2'b00,
		NST_INACTIVE = 2'b01,
		NST_ERROR = 2'b10
	} net_status_e;

endpackage

// ---- design/net_txn.sv ----
// Holds one request toward the network master until it answers or times out.
// Assumes the network master pulses its acknowledge on the block clock.
`timescale 1ns/10ps
module net_txn import mbox_pkg::*; #(
	parameter int TIMEOUT_CYC = NET_TIMEOUT_CYC
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic start,
	input wire net_op_e op,
	input wire logic [7:0] addr,
	input wire logic [7:0] arg,
	input wire logic [63:0] wdata,
	output logic done_q,
	output net_status_e status_q,
	output logic [63:0] rdata_q,
	output logic NET_REQ,
	output net_op_e NET_OP,
	output logic [7:0] NET_ADDR,
	output logic [7:0] NET_ARG,
	output logic [63:0] NET_WDATA,
	input wire logic NET_ACK,
	input wire logic [1:0] NET_STATUS,
	input wire logic [63:0] NET_RDATA
);

	logic [31:0] timer_q;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			NET_REQ <= 1'b0;
			NET_OP <= OP_READ_CFG;
			NET_ADDR <= BYTE_RESET;
			NET_ARG <= BYTE_RESET;
			NET_WDATA <= 64'h0;
		end else if (start) begin
			NET_REQ <= 1'b1;
			NET_OP <= op;
			NET_ADDR <= addr;
			NET_ARG <= arg;
			NET_WDATA <= wdata;
		end else if (NET_ACK || timer_q == 32'(TIMEOUT_CYC)) begin
			NET_REQ <= 1'b0;
		end
	end

	// A silent master must not hang the mailbox, so a stuck request ends as a network error.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			timer_q <= 32'h0;
		end else if (start || !NET_REQ) begin
			timer_q <= 32'h0;
		end else begin
			timer_q <= timer_q + 32'h1;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			done_q <= 1'b0;
			status_q <= NST_OK;
			rdata_q <= 64'h0;
		end else begin
			done_q <= NET_REQ && (NET_ACK || timer_q == 32'(TIMEOUT_CYC));
			if (NET_REQ && NET_ACK) begin
				status_q <= (NET_STATUS == 2'b00) ? NST_OK :
					(NET_STATUS == 2'b01) ? NST_INACTIVE : NST_ERROR;
				rdata_q <= NET_RDATA;
			end else if (NET_REQ && timer_q == 32'(TIMEOUT_CYC)) begin
				status_q <= NST_ERROR;
			end
		end
	end

endmodule

// ---- design/cmd_mailbox.sv ----
// Command mailbox of the fieldbus converter: request and response image, flag handshake
// and command decode. Assumes the link image and flags arrive on the block clock.
`timescale 1ns/10ps
module cmd_mailbox import mbox_pkg::*; #(
	parameter bit ANALOG_REV = 1'b1,
	parameter int TIMEOUT_CYC = NET_TIMEOUT_CYC
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic WR_EN,
	input wire logic WR_AREA,
	input wire logic [4:0] WR_ADDR,
	input wire logic [7:0] WR_DATA,
	input wire logic RD_AREA,
	input wire logic [4:0] RD_ADDR,
	output logic [7:0] RD_DATA,
	input wire logic REQ_FLAG,
	output logic END_FLAG,
	input wire logic ZERO_SLAVE_PRESENT,
	output logic NET_REQ,
	output net_op_e NET_OP,
	output logic [7:0] NET_ADDR,
	output logic [7:0] NET_ARG,
	output logic [63:0] NET_WDATA,
	input wire logic NET_ACK,
	input wire logic [1:0] NET_STATUS,
	input wire logic [63:0] NET_RDATA
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_DONE = 2'b10
	} state_e;

	state_e state_q;
	logic [7:0] req_q [2][32];
	logic [7:0] rsp_q [2][32];
	logic [7:0] cmd;
	logic [7:0] slave;
	logic [7:0] verdict;
	logic start;
	net_op_e op;
	logic [63:0] wdata;
	logic txn_done;
	net_status_e txn_status;
	logic [63:0] txn_rdata;
	net_op_e op_q;

	// Standard and A slaves sit at 01h..1fh; B slaves are shifted up by 20h.
	function automatic logic addr_ok(input logic [7:0] a, input logic allow_b); // [RULE_08] [RULE_09]
		addr_ok = (a >= ADDR_MIN && a <= ADDR_MAX_A) ||
			(allow_b && a >= ADDR_MIN + ADDR_B_OFFSET && a <= ADDR_MAX_B);
	endfunction

	assign cmd = req_q[0][OFS_CMD];
	assign slave = req_q[0][OFS_PRM0];

	// Checks run in order so that no slave is contacted for a malformed request.
	always_comb begin
		verdict = RES_OK;
		op = OP_READ_CFG;
		unique case (cmd)
			CMD_READ_CFG: begin
				if (!addr_ok(slave, 1'b1)) verdict = RES_ADDR; // [RULE_14]
				op = OP_READ_CFG;
			end
			CMD_CHG_ADDR: begin
				if (!addr_ok(slave, 1'b1) || !addr_ok(req_q[0][OFS_PRM1], 1'b1)) begin
					verdict = RES_ADDR; // [RULE_02] [RULE_14]
				end else if (ZERO_SLAVE_PRESENT) begin
					verdict = RES_ZERO_SLAVE; // [RULE_03]
				end
				op = OP_CHG_ADDR;
			end
			CMD_AIN, CMD_AOUT: begin
				if (!ANALOG_REV) verdict = RES_NOT_EXEC; // [RULE_07]
				else if (!addr_ok(slave, 1'b0)) verdict = RES_ADDR; // [RULE_04] [RULE_14]
				op = (cmd == CMD_AIN) ? OP_AIN : OP_AOUT;
			end
			default: verdict = RES_UNKNOWN; // [RULE_13]
		endcase
	end

	// Output channels are passed high byte first, channel 1 in the top bits.
	assign wdata = {req_q[0][OFS_PRM1], req_q[0][OFS_PRM2], req_q[0][OFS_PRM3],
		req_q[0][OFS_PRM4], req_q[1][OFS_PRM0], req_q[1][OFS_PRM1],
		req_q[1][OFS_PRM2], req_q[1][OFS_PRM3]}; // [RULE_06]
	assign start = state_q == ST_IDLE && REQ_FLAG && verdict == RES_OK; // [RULE_11]

	net_txn #(
		.TIMEOUT_CYC(TIMEOUT_CYC)
	) u_txn (
		.CLK(CLK),
		.ARST_N(ARST_N),
		.start(start),
		.op(op),
		.addr(slave),
		.arg(req_q[0][OFS_PRM1]),
		.wdata(wdata),
		.done_q(txn_done),
		.status_q(txn_status),
		.rdata_q(txn_rdata),
		.NET_REQ(NET_REQ),
		.NET_OP(NET_OP),
		.NET_ADDR(NET_ADDR),
		.NET_ARG(NET_ARG),
		.NET_WDATA(NET_WDATA),
		.NET_ACK(NET_ACK),
		.NET_STATUS(NET_STATUS),
		.NET_RDATA(NET_RDATA)
	);

	// The request image is written by the host only; the block never alters it.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int a = 0; a < 2; a++) begin
				for (int i = 0; i < 32; i++) begin
					req_q[a][i] <= BYTE_RESET;
				end
			end
		end else if (WR_EN) begin
			req_q[WR_AREA][WR_ADDR] <= WR_DATA;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_q <= ST_IDLE;
			op_q <= OP_READ_CFG;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (REQ_FLAG) begin
						state_q <= (verdict == RES_OK) ? ST_WAIT : ST_DONE;
						op_q <= op;
					end
				end
				ST_WAIT: begin
					if (txn_done) state_q <= ST_DONE;
				end
				ST_DONE: begin
					if (!REQ_FLAG) state_q <= ST_IDLE; // [RULE_12]
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// The end flag rises on the same edge that posts the result; RD_DATA is registered, so for one
	// cycle the host can see a raised end flag over the old response bytes.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			END_FLAG <= 1'b0;
		end else if (state_q == ST_IDLE && REQ_FLAG && verdict != RES_OK) begin
			END_FLAG <= 1'b1; // [RULE_11]
		end else if (state_q == ST_WAIT && txn_done) begin
			END_FLAG <= 1'b1; // [RULE_11]
		end else if (state_q == ST_DONE && !REQ_FLAG) begin
			END_FLAG <= 1'b0; // [RULE_12]
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int a = 0; a < 2; a++) begin
				for (int i = 0; i < 32; i++) begin
					rsp_q[a][i] <= BYTE_RESET;
				end
			end
		end else if (state_q == ST_IDLE && REQ_FLAG) begin
			rsp_q[0][OFS_RESULT] <= verdict; // [RULE_13]
			for (int i = 0; i < 4; i++) begin
				rsp_q[0][OFS_RSP0 + 5'(i)] <= BYTE_RESET;
				rsp_q[1][OFS_RSP0 + 5'(i)] <= BYTE_RESET;
			end
		end else if (state_q == ST_WAIT && txn_done) begin
			unique case (txn_status)
				NST_OK: rsp_q[0][OFS_RESULT] <= RES_OK;
				NST_INACTIVE: rsp_q[0][OFS_RESULT] <= RES_INACTIVE;
				default: rsp_q[0][OFS_RESULT] <= RES_NET;
			endcase
			if (txn_status == NST_OK && op_q == OP_READ_CFG) begin
				rsp_q[0][OFS_RSP0] <= txn_rdata[7:0] & NIBBLE_MASK; // [RULE_01]
				rsp_q[0][OFS_RSP1] <= txn_rdata[15:8] & NIBBLE_MASK; // [RULE_01]
			end
			if (txn_status == NST_OK && op_q == OP_AIN) begin
				for (int i = 0; i < 4; i++) begin
					rsp_q[0][OFS_RSP0 + 5'(i)] <= txn_rdata[63 - 8 * i -: 8]; // [RULE_05]
					rsp_q[1][OFS_RSP0 + 5'(i)] <= txn_rdata[31 - 8 * i -: 8]; // [RULE_05]
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RD_DATA <= BYTE_RESET;
		end else begin
			RD_DATA <= rsp_q[RD_AREA][RD_ADDR];
		end
	end

endmodule

// ---- dv/cmd_mailbox_checker.sv ----
// Port checker for the command mailbox handshake and its network requests.
// Assumes it is bound into the mailbox and sees only its top ports.
`timescale 1ns/10ps
module cmd_mailbox_checker import mbox_pkg::*; #(
	parameter bit ANALOG_REV = 1'b1,
	parameter int TIMEOUT_CYC = NET_TIMEOUT_CYC
) (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic REQ_FLAG,
	input wire logic END_FLAG,
	input wire logic ZERO_SLAVE_PRESENT,
	input wire logic NET_REQ,
	input wire net_op_e NET_OP,
	input wire logic [7:0] NET_ADDR,
	input wire logic NET_ACK
);
	int req_cyc_q;
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			req_cyc_q <= 0;
		else
			req_cyc_q <= NET_REQ ? req_cyc_q + 1 : 0;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	sequence s_ack;
		NET_REQ && NET_ACK;
	endsequence
	sequence s_post;
		!NET_REQ ##1 END_FLAG;
	endsequence
	a_ack_to_end: assert property (s_ack |=> s_post)
		else $error("end flag late after ack");
	a_end_hold: assert property (END_FLAG && REQ_FLAG |=> END_FLAG)
		else $error("end flag lost while request high");
	a_end_drop: assert property (END_FLAG && !REQ_FLAG |=> !END_FLAG)
		else $error("end flag kept after request low");
	a_end_rise: assert property ($rose(END_FLAG) |-> REQ_FLAG && !NET_REQ)
		else $error("end flag raised out of turn");
	a_net_launch: assert property ($rose(NET_REQ) |-> $past(REQ_FLAG) && !END_FLAG)
		else $error("network request without command");
	a_addr_range: assert property ($rose(NET_REQ) |-> NET_ADDR inside {[8'h01:8'h1f], [8'h21:8'h3f]})
		else $error("bad address sent to network");
	a_analog_addr: assert property ($rose(NET_REQ) && NET_OP inside {OP_AIN, OP_AOUT}
		|-> NET_ADDR inside {[8'h01:8'h1f]})
		else $error("analog command with B address");
	a_zero_block: assert property ($rose(NET_REQ) && NET_OP == OP_CHG_ADDR
		|-> !$past(ZERO_SLAVE_PRESENT))
		else $error("address change with zero slave");
	a_rev_gate: assert property ($rose(NET_REQ) |-> ANALOG_REV || !NET_OP[1])
		else $error("analog command on old revision");
	a_net_bound: assert property (req_cyc_q <= TIMEOUT_CYC + 2)
		else $error("network request never times out");
endmodule

// ---- dv/net_master_model.sv ----
// Network master model: acknowledges each request after a set wait.
// Assumes the bench sets wait, status and read data before a command.
`timescale 1ns/10ps
module net_master_model import mbox_pkg::*; (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic NET_REQ,
	input wire logic [7:0] dly,
	input wire logic [1:0] stat,
	input wire logic [63:0] rdat,
	output logic NET_ACK,
	output logic [1:0] NET_STATUS,
	output logic [63:0] NET_RDATA
);
	int wait_q;
	logic hit;
	assign hit = NET_REQ && !NET_ACK && wait_q >= int'(dly);
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wait_q <= 0;
			NET_ACK <= 1'b0;
			NET_STATUS <= 2'h0;
			NET_RDATA <= 64'h0;
		end else begin
			wait_q <= NET_REQ && !NET_ACK ? wait_q + 1 : 0;
			NET_ACK <= hit;
			// Idle lines toggle so a stale value is never mistaken for an answer.
			NET_STATUS <= hit ? stat : ~NET_STATUS;
			NET_RDATA <= hit ? rdat : ~NET_RDATA;
		end
	end
endmodule

// ---- dv/fieldbus_slave_command_mailbox_test.sv ----
// Random command bench for the mailbox against a reference built in the bench.
// Assumes the mailbox, the network model and the bound checker.
`timescale 1ns/10ps
module fieldbus_slave_command_mailbox_test import mbox_pkg::*;;
	localparam int TMO = 20;
	logic CLK = 1'b0, ARST_N = 1'b0, WR_EN = 1'b0, WR_AREA = 1'b0, RD_AREA = 1'b0;
	logic REQ_FLAG = 1'b0, ZERO_SLAVE_PRESENT = 1'b0, END_FLAG, NET_REQ, NET_ACK, n_hit;
	logic [4:0] WR_ADDR = 5'h00, RD_ADDR = 5'h00;
	logic [7:0] WR_DATA = 8'h00, RD_DATA, NET_ADDR, NET_ARG, dly = 8'h01;
	logic [1:0] NET_STATUS, stat = 2'h0;
	logic [63:0] NET_WDATA, NET_RDATA, rdat = 64'h0;
	logic [81:0] n_got;
	logic [31:0] lfsr = 32'heea4;
	net_op_e NET_OP;
	int mismatches = 0, cmp_count = 0, t;
	logic [7:0] cmds [5] = '{CMD_READ_CFG, CMD_CHG_ADDR, CMD_AIN, CMD_AOUT, 8'h0b};
	// Boundaries of both address kinds; B slaves carry the 20h offset.
	logic [7:0] av [8] = '{8'h00, 8'h01, 8'h1f, 8'h20, 8'h21, 8'h3f, 8'h40, 8'h2a};
	cmd_mailbox #(.TIMEOUT_CYC(TMO)) dut_u (.CLK, .ARST_N, .WR_EN, .WR_AREA, .WR_ADDR,
		.WR_DATA, .RD_AREA, .RD_ADDR, .RD_DATA, .REQ_FLAG, .END_FLAG, .ZERO_SLAVE_PRESENT,
		.NET_REQ, .NET_OP, .NET_ADDR, .NET_ARG, .NET_WDATA, .NET_ACK, .NET_STATUS, .NET_RDATA);
	net_master_model net_u (.CLK, .ARST_N, .NET_REQ, .dly, .stat, .rdat, .NET_ACK,
		.NET_STATUS, .NET_RDATA);
	initial begin
		forever #2.5 CLK = ~CLK;
	end
	// Sampled away from the launching edge so the captured request is settled.
	always @(negedge CLK) begin
		if (NET_REQ) begin
			n_hit = 1'b1;
			n_got = {NET_OP, NET_ADDR, NET_ARG, NET_WDATA};
		end
	end
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic bit ok(input logic [7:0] v);
		return v >= 8'h01 && v <= 8'h3f && v != 8'h20;
	endfunction
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic cmp(input logic [95:0] got, input logic [95:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic ar, input logic [4:0] a, input logic [7:0] d);
		@(negedge CLK);
		WR_EN = 1'b1;
		WR_AREA = ar;
		WR_ADDR = a;
		WR_DATA = d;
	endtask
	task automatic rd(input logic ar, input logic [4:0] a, output logic [7:0] d);
		@(negedge CLK);
		RD_AREA = ar;
		RD_ADDR = a;
		@(negedge CLK);
		d = RD_DATA;
	endtask
	task automatic wait_end(input logic lvl);
		for (int i = 0; i < 100 && END_FLAG !== lvl; i++) @(negedge CLK);
		if (END_FLAG !== lvl) begin
			mismatches++;
			report_and_stop;
		end
	endtask
	task automatic run(input logic [7:0] c, input logic [7:0] a, input logic [63:0] wd);
		logic [7:0] res, g, b;
		logic [63:0] exp;
		logic [1:0] op;
		bit net;
		b = wd[63:56];
		res = RES_UNKNOWN;
		if (c == CMD_READ_CFG || c == CMD_CHG_ADDR)
			res = ok(a) && (c == CMD_READ_CFG || ok(b)) ? RES_OK : RES_ADDR;
		if (c == CMD_AIN || c == CMD_AOUT)
			res = a >= 8'h01 && a <= 8'h1f ? RES_OK : RES_ADDR;
		if (c == CMD_CHG_ADDR && res == RES_OK && ZERO_SLAVE_PRESENT)
			res = RES_ZERO_SLAVE;
		net = res == RES_OK;
		if (net)
			res = dly > TMO ? RES_NET : stat == 2'h0 ? RES_OK : stat == 2'h1 ? RES_INACTIVE : RES_NET;
		exp = 64'h0;
		if (res == RES_OK && c == CMD_READ_CFG)
			exp = {4'h0, rdat[3:0], 4'h0, rdat[11:8], 48'h0};
		if (res == RES_OK && c == CMD_AIN)
			exp = rdat;
		op = c == CMD_CHG_ADDR ? 2'h1 : c == CMD_AIN ? 2'h2 : c == CMD_AOUT ? 2'h3 : 2'h0;
		n_hit = 1'b0;
		wr(1'b0, OFS_CMD, c);
		wr(1'b0, OFS_PRM0, a);
		for (int k = 0; k < 8; k++) wr(k > 3, k > 3 ? 5'(14 + k) : 5'(19 + k), wd[63 - 8 * k -: 8]);
		@(negedge CLK);
		WR_EN = 1'b0;
		REQ_FLAG = 1'b1;
		wait_end(1'b1);
		rd(1'b0, OFS_RESULT, g);
		cmp(g, res);
		for (int k = 0; k < 8; k++) begin
			rd(k > 3, 5'(26 + k % 4), g);
			cmp(g, exp[63 - 8 * k -: 8]);
		end
		cmp(n_hit, net);
		if (net)
			cmp(n_got, {op, a, b, wd});
		REQ_FLAG = 1'b0;
		wait_end(1'b0);
	endtask
	initial begin
		repeat (10) @(negedge CLK);
		ARST_N = 1'b1;
		for (t = 0; t < 60; t++) begin
			lfsr = nxt(lfsr);
			rdat = {lfsr, nxt(lfsr)};
			stat = lfsr[6] ? 2'h0 : lfsr[1:0];
			dly = lfsr[3:2] == 2'h0 ? 8'h3c : {6'h0, lfsr[5:4]};
			ZERO_SLAVE_PRESENT = lfsr[7];
			run(cmds[t % 5], lfsr[11] ? av[lfsr[10:8]] : {2'h0, lfsr[17:12]},
				{lfsr[18] ? av[lfsr[21:19]] : lfsr[29:22], nxt(nxt(lfsr)), lfsr[23:0]});
			$display("test %0d command %h finished", t, cmds[t % 5]);
		end
		report_and_stop;
	end
endmodule
bind cmd_mailbox cmd_mailbox_checker #(.ANALOG_REV(ANALOG_REV), .TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (
	.CLK, .ARST_N, .REQ_FLAG, .END_FLAG, .ZERO_SLAVE_PRESENT, .NET_REQ, .NET_OP, .NET_ADDR,
	.NET_ACK);
